// file: hw/ejc_pkg.sv
package ejc_pkg;

    // ----------------------------------------------------------------
    // Clock and timing
    // ----------------------------------------------------------------
    localparam longint CLK_HZ = 20_000_000;
    localparam longint KEY_HOLD_MS = 3000;
    localparam longint UNLOCK_MS = 60000;
    localparam longint FLASH_MS = 250;
    localparam longint KEY_HOLD_CYCLES = KEY_HOLD_MS * CLK_HZ / 1000;
    localparam longint UNLOCK_CYCLES = UNLOCK_MS * CLK_HZ / 1000;
    localparam longint FLASH_CYCLES = FLASH_MS * CLK_HZ / 1000;

    // ----------------------------------------------------------------
    // Register map (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_THR = 8'h04;
    localparam logic [7:0] OFS_PIN = 8'h08;
    localparam logic [7:0] OFS_UNLOCK = 8'h0c;
    localparam logic [7:0] OFS_ZERO = 8'h10;
    localparam logic [7:0] OFS_STATUS = 8'h14;
    localparam logic [7:0] OFS_CNT1 = 8'h18;
    localparam logic [7:0] OFS_CNT2 = 8'h1c;

    localparam int CFG_W = 9;
    localparam int VAC_W = 12;
    localparam int PIN_W = 16;
    localparam int CNT_W = 30;
    localparam int THR_OFF_LSB = 16;

    // ----------------------------------------------------------------
    // Field types and reset values
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {
        UNIT_MBAR = 2'b00,
        UNIT_KPA = 2'b01,
        UNIT_INHG = 2'b10
    } ejc_unit_t;

    typedef struct packed {
        logic vac_ctrl;
        logic cnt_sel;
        logic cnt_view;
        logic reset_item;
        logic rotated;
        logic nc_contact;
        logic sinking;
        ejc_unit_t unit;
    } ejc_cfg_t;

    typedef struct packed {
        logic up;
        logic down;
        logic menu;
        logic enter;
    } ejc_keys_t;

    typedef enum logic {
        MODE_AUTO = 1'b0,
        MODE_MANUAL = 1'b1
    } ejc_mode_t;

    typedef enum logic [3:0] {
        ERR_NONE = 4'h0,
        ERR_CAL_RANGE = 4'h3,
        ERR_UNDERVOLT = 4'h5
    } ejc_err_t;

    localparam ejc_cfg_t CFG_DEF = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, UNIT_MBAR};
    localparam logic [VAC_W-1:0] ON_THR_DEF = 12'h2ee;
    localparam logic [VAC_W-1:0] OFF_THR_DEF = 12'h258;
    localparam logic [PIN_W-1:0] PIN_DEF = 16'h0000;
    localparam logic signed [VAC_W-1:0] VAC_FULL_SCALE = 12'h7ff;
    localparam logic signed [VAC_W-1:0] CAL_LIMIT = 12'h03d;
    localparam logic [1:0] PAGE_LAST = 2'h2;
    localparam logic [CNT_W-1:0] PAGE_DIV = 30'h3e8;

endpackage : ejc_pkg

// file: hw/ejc_ctrl.sv
// Implementation choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
// Functional notes
// [R1] Out of reset the block is operational in automatic mode following the inputs.
// [R2] Parameter changes are accepted only in automatic mode.
// [R3] UP and DOWN held together over 3 s enter manual mode.
// [R4] Both status lamps flash together while manual mode is active.
// [R5] Valve protection is disabled for the whole manual mode.
// [R6] Manual mode may be entered without actuator supply voltage.
// [R7] Manual: UP turns suction on; UP or DOWN turns it off.
// [R8] Manual blow-off lasts only while DOWN stays pressed.
// [R9] Without actuator voltage manual blow-off is refused and undervoltage shown.
// [R10] Enabled vacuum control stays active in manual; vacuum shown, not undervoltage.
// [R11] MENU ends manual mode when neither suction nor blow-off is active.
// [R12] Any change of the external inputs ends manual mode at once.
// [R13] Display unit setting: millibar, kilopascal or inches of mercury.
// [R14] One setting picks sourcing or sinking for inputs and output; default sourcing.
// [R15] Output contact normally open or normally closed, inverting the output.
// [R16] Switched output follows part-present comparison with on and off thresholds.
// [R17] Rotated display swaps the meanings of UP and DOWN.
// [R18] With a PIN set, edits allowed one minute after unlock; default PIN unlocks.
// [R19] Zero calibration accepted only within 3 percent of full scale, else error.
// [R20] ENTER held 3 s on reset item restores factory settings, counters kept.
// [R21] Counter 1 counts suction input pulses; counter 2 counts suction valve switch-ons.
// [R22] Counters shown in pages of three decimal digits, stepped by UP and DOWN.
// [R23] External blow-off cancels suction and blows exactly while asserted.
// [R24] Hold and unlock timers count clock cycles and restart when condition ends.
module ejc_ctrl
#(
    parameter longint HOLD_CYCLES = ejc_pkg::KEY_HOLD_CYCLES,
    parameter longint UNLOCK_WIN_CYCLES = ejc_pkg::UNLOCK_CYCLES,
    parameter longint FLASH_HALF_CYCLES = ejc_pkg::FLASH_CYCLES
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ejc_pkg::ejc_keys_t key_pins,
    input wire logic suction_in_pin,
    input wire logic blow_in_pin,
    input wire logic actuator_volt_ok,
    input wire logic signed [ejc_pkg::VAC_W-1:0] vacuum_raw,
    output logic suction_valve,
    output logic blow_valve,
    output logic switch_out_pin,
    output logic first_status_lamp,
    output logic second_status_lamp,
    output logic valve_protect_en,
    output logic [9:0] disp_value,
    output logic [2:0] disp_dp,
    output ejc_pkg::ejc_err_t disp_err,
    output ejc_pkg::ejc_unit_t disp_unit,
    output logic disp_rotated
);
    import ejc_pkg::*;

    if (HOLD_CYCLES < 1 || UNLOCK_WIN_CYCLES < 1 || FLASH_HALF_CYCLES < 1 ||
        UNLOCK_WIN_CYCLES > 64'h7fff_ffff || HOLD_CYCLES > 64'h7fff_ffff) begin : g_bad
        $error("ejc_ctrl: timing counts out of range");
    end

    localparam logic [31:0] HOLD_N = 32'(HOLD_CYCLES);
    localparam logic [31:0] UNLOCK_N = 32'(UNLOCK_WIN_CYCLES);
    localparam logic [31:0] FLASH_N = 32'(FLASH_HALF_CYCLES);

    function automatic logic [9:0] page_of(input logic [CNT_W-1:0] cnt, input logic [1:0] page);
        logic [CNT_W-1:0] v;
        v = cnt;
        for (int i = 0; i < 2; i++) begin
            if (page > 2'(i)) begin
                v = v / PAGE_DIV;
            end
        end
        return 10'(v % PAGE_DIV);
    endfunction : page_of

    function automatic logic [31:0] run_timer(input logic cond, input logic [31:0] t);
        return cond ? ((t == 32'hffff_ffff) ? t : t + 32'h1) : 32'h0;
    endfunction : run_timer

    // ----------------------------------------------------------------
    // Input synchronisers and edge detection
    // ----------------------------------------------------------------
    logic [6:0] sync_a;
    logic [6:0] sync_b;
    logic [6:0] sync_d;
    ejc_cfg_t cfg;
    ejc_keys_t key;
    ejc_keys_t key_press;
    logic sig_suction;
    logic sig_blow;
    logic act_ok;
    logic ext_change;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_a <= 7'h00;
            sync_b <= 7'h00;
            sync_d <= 7'h00;
        end else begin
            sync_a <= {actuator_volt_ok, blow_in_pin, suction_in_pin, key_pins};
            sync_b <= sync_a;
            sync_d <= sync_b;
        end
    end

    always_comb begin
        key.up = cfg.rotated ? sync_b[2] : sync_b[3]; // [R17]
        key.down = cfg.rotated ? sync_b[3] : sync_b[2]; // [R17]
        key.menu = sync_b[1];
        key.enter = sync_b[0];
        key_press.up = key.up & ~(cfg.rotated ? sync_d[2] : sync_d[3]);
        key_press.down = key.down & ~(cfg.rotated ? sync_d[3] : sync_d[2]);
        key_press.menu = sync_b[1] & ~sync_d[1];
        key_press.enter = sync_b[0] & ~sync_d[0];
        sig_suction = sync_b[4] ^ cfg.sinking; // [R14]
        sig_blow = sync_b[5] ^ cfg.sinking; // [R14]
        act_ok = sync_b[6];
        ext_change = (sync_b[5:4] != sync_d[5:4]);
    end

    // ----------------------------------------------------------------
    // Operating mode
    // ----------------------------------------------------------------
    ejc_mode_t mode;
    logic [31:0] both_timer;
    logic [31:0] enter_timer;
    logic wait_release;
    logic man_suction;
    logic man_blow;
    logic blow_refused;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            both_timer <= 32'h0;
            enter_timer <= 32'h0;
        end else begin
            both_timer <= run_timer(key.up & key.down & mode == MODE_AUTO, both_timer); // [R24]
            enter_timer <= run_timer(key.enter, enter_timer); // [R24]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_AUTO; // [R1]
            wait_release <= 1'b0;
        end else begin
            case (mode)
                MODE_AUTO: begin
                    if (both_timer >= HOLD_N) begin // [R3] [R6]
                        mode <= MODE_MANUAL;
                        wait_release <= 1'b1;
                    end
                end
                MODE_MANUAL: begin
                    if (ext_change) begin // [R12]
                        mode <= MODE_AUTO;
                    end else if (key_press.menu && !man_suction && !man_blow) begin // [R11]
                        mode <= MODE_AUTO;
                    end
                    if (!key.up && !key.down) begin
                        wait_release <= 1'b0;
                    end
                end
                default: begin
                    mode <= MODE_AUTO;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Manual suction and blow-off
    // ----------------------------------------------------------------
    logic manual_keys;

    assign manual_keys = (mode == MODE_MANUAL) && !wait_release && !ext_change;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_suction <= 1'b0;
        end else if (!manual_keys) begin
            man_suction <= 1'b0;
        end else if (man_suction && (key_press.up || key_press.down)) begin // [R7]
            man_suction <= 1'b0;
        end else if (!man_suction && key_press.up) begin // [R7]
            man_suction <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            man_blow <= 1'b0;
            blow_refused <= 1'b0;
        end else begin
            man_blow <= manual_keys && !man_suction && key.down && act_ok; // [R8] [R9]
            blow_refused <= manual_keys && !man_suction && key.down && !act_ok; // [R9]
        end
    end

    // ----------------------------------------------------------------
    // Vacuum, part-present and valves
    // ----------------------------------------------------------------
    logic signed [VAC_W-1:0] zero_ofs;
    logic [VAC_W-1:0] on_thr;
    logic [VAC_W-1:0] off_thr;
    logic [VAC_W-1:0] vac_level;
    logic part_present;
    logic vac_hold_off;
    logic signed [VAC_W:0] vac_diff;

    assign vac_diff = (VAC_W+1)'(vacuum_raw) - (VAC_W+1)'(zero_ofs);
    assign vac_level = vac_diff[VAC_W] ? '0 : vac_diff[VAC_W-1:0];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            part_present <= 1'b0;
        end else if (vac_level >= on_thr) begin // [R16]
            part_present <= 1'b1;
        end else if (vac_level < off_thr) begin // [R16]
            part_present <= 1'b0;
        end
    end

    // Vacuum control: valve rests above the on threshold, resumes below the off one
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vac_hold_off <= 1'b0;
        end else if (!cfg.vac_ctrl) begin
            vac_hold_off <= 1'b0;
        end else if (vac_level >= on_thr) begin // [R10]
            vac_hold_off <= 1'b1;
        end else if (vac_level < off_thr) begin
            vac_hold_off <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            suction_valve <= 1'b0;
            blow_valve <= 1'b0;
            switch_out_pin <= 1'b0;
        end else if (mode == MODE_MANUAL) begin
            suction_valve <= man_suction && !vac_hold_off; // [R10]
            blow_valve <= man_blow; // [R8]
            switch_out_pin <= part_present ^ cfg.nc_contact ^ cfg.sinking; // [R15] [R14]
        end else begin
            suction_valve <= sig_suction && !sig_blow && !vac_hold_off; // [R1] [R23]
            blow_valve <= sig_blow; // [R23]
            switch_out_pin <= part_present ^ cfg.nc_contact ^ cfg.sinking; // [R15] [R14]
        end
    end

    // ----------------------------------------------------------------
    // Lifetime counters
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt1;
    logic [CNT_W-1:0] cnt2;
    logic suction_valve_d;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt1 <= '0;
            cnt2 <= '0;
            suction_valve_d <= 1'b0;
        end else begin
            suction_valve_d <= suction_valve;
            if (sync_b[4] != sync_d[4] && sig_suction) begin // [R21]
                cnt1 <= cnt1 + 1'b1;
            end
            if (suction_valve && !suction_valve_d) begin // [R21]
                cnt2 <= cnt2 + 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Write protection and register writes
    // ----------------------------------------------------------------
    logic [PIN_W-1:0] pin;
    logic [31:0] unlock_timer;
    logic edit_ok;
    logic wr_req;
    logic wr_cfg;
    logic cal_err;
    logic factory_reset;

    assign edit_ok = (mode == MODE_AUTO) && (pin == PIN_DEF || unlock_timer != 32'h0); // [R2] [R18]
    assign wr_req = psel && penable && pwrite;
    assign wr_cfg = wr_req && edit_ok && (paddr == OFS_CFG || paddr == OFS_THR ||
                    paddr == OFS_PIN || paddr == OFS_ZERO);
    assign factory_reset = edit_ok && cfg.reset_item && enter_timer == HOLD_N; // [R20]

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            unlock_timer <= 32'h0;
        end else if (wr_req && paddr == OFS_UNLOCK && pwdata[PIN_W-1:0] == pin) begin // [R18]
            unlock_timer <= UNLOCK_N;
        end else if (wr_cfg && unlock_timer != 32'h0) begin // [R18] [R24]
            unlock_timer <= UNLOCK_N;
        end else if (unlock_timer != 32'h0) begin
            unlock_timer <= unlock_timer - 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg <= CFG_DEF; // [R14]
            on_thr <= ON_THR_DEF;
            off_thr <= OFF_THR_DEF;
            zero_ofs <= '0;
            cal_err <= 1'b0;
        end else if (factory_reset) begin // [R20]
            cfg <= CFG_DEF;
            on_thr <= ON_THR_DEF;
            off_thr <= OFF_THR_DEF;
            zero_ofs <= '0;
            cal_err <= 1'b0;
        end else if (wr_cfg) begin
            case (paddr)
                OFS_CFG: begin
                    cfg <= ejc_cfg_t'(pwdata[CFG_W-1:0]); // [R13] [R15] [R17]
                end
                OFS_THR: begin
                    on_thr <= pwdata[VAC_W-1:0];
                    off_thr <= pwdata[THR_OFF_LSB +: VAC_W];
                end
                OFS_ZERO: begin
                    if (vacuum_raw <= CAL_LIMIT && vacuum_raw >= -CAL_LIMIT) begin // [R19]
                        zero_ofs <= vacuum_raw;
                        cal_err <= 1'b0;
                    end else begin
                        cal_err <= 1'b1; // [R19]
                    end
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin <= PIN_DEF;
        end else if (wr_cfg && paddr == OFS_PIN) begin
            pin <= pwdata[PIN_W-1:0]; // [R18]
        end
    end

    // ----------------------------------------------------------------
    // APB read and response
    // ----------------------------------------------------------------
    logic [31:0] next_prdata;
    logic addr_ok;

    assign addr_ok = (paddr <= OFS_CNT2) && (paddr[1:0] == 2'b00);
    assign pready = 1'b1;
    assign pslverr = psel && penable && (!addr_ok || (pwrite && !edit_ok &&
                     paddr != OFS_UNLOCK && paddr != OFS_STATUS &&
                     paddr != OFS_CNT1 && paddr != OFS_CNT2));

    always_comb begin
        next_prdata = 32'h0;
        case (paddr)
            OFS_CFG: next_prdata = 32'(cfg);
            OFS_THR: next_prdata = {4'h0, off_thr, 4'h0, on_thr};
            OFS_PIN: next_prdata = 32'(pin == PIN_DEF);
            OFS_ZERO: next_prdata = 32'(zero_ofs);
            OFS_STATUS: next_prdata = {20'h0, disp_err, part_present, !edit_ok,
                                      blow_valve, suction_valve, cal_err, 2'b00, mode};
            OFS_CNT1: next_prdata = 32'(cnt1);
            OFS_CNT2: next_prdata = 32'(cnt2);
            default: next_prdata = 32'h0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // ----------------------------------------------------------------
    // Lamps, display and counter pages
    // ----------------------------------------------------------------
    logic [31:0] flash_timer;
    logic flash;
    logic [1:0] page;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            flash_timer <= 32'h0;
            flash <= 1'b0;
        end else if (mode != MODE_MANUAL || flash_timer >= FLASH_N - 32'h1) begin
            flash_timer <= 32'h0;
            flash <= (mode == MODE_MANUAL) ? !flash : 1'b0;
        end else begin
            flash_timer <= flash_timer + 32'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            page <= 2'h0;
        end else if (mode != MODE_AUTO || !cfg.cnt_view) begin
            page <= 2'h0; // [R22]
        end else if (key_press.up && !key.down) begin
            page <= (page == PAGE_LAST) ? 2'h0 : page + 2'h1; // [R22]
        end else if (key_press.down && !key.up) begin
            page <= (page == 2'h0) ? PAGE_LAST : page - 2'h1; // [R22]
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_status_lamp <= 1'b0;
            second_status_lamp <= 1'b0;
            valve_protect_en <= 1'b1;
            disp_value <= 10'h0;
            disp_dp <= 3'h0;
            disp_err <= ERR_NONE;
            disp_unit <= UNIT_MBAR;
            disp_rotated <= 1'b0;
        end else begin
            first_status_lamp <= (mode == MODE_MANUAL) ? flash : suction_valve; // [R4]
            second_status_lamp <= (mode == MODE_MANUAL) ? flash : part_present; // [R4]
            valve_protect_en <= (mode == MODE_AUTO); // [R5]
            disp_unit <= cfg.unit; // [R13]
            disp_rotated <= cfg.rotated; // [R17]
            if (cfg.cnt_view && mode == MODE_AUTO) begin
                disp_value <= page_of(cfg.cnt_sel ? cnt2 : cnt1, page); // [R22]
                disp_dp <= 3'b001 << page; // [R22]
            end else begin
                disp_value <= vac_level[9:0];
                disp_dp <= 3'h0;
            end
            if (cal_err) begin
                disp_err <= ERR_CAL_RANGE; // [R19]
            end else if (blow_refused ||
                         (mode == MODE_MANUAL && !act_ok && !cfg.vac_ctrl)) begin // [R9] [R10]
                disp_err <= ERR_UNDERVOLT;
            end else begin
                disp_err <= ERR_NONE;
            end
        end
    end

endmodule : ejc_ctrl

// file: tb/ejc_ctrl_asserts.sv
`timescale 1ns/1ns
module ejc_ctrl_asserts (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic suction_in_pin,
    input wire logic actuator_volt_ok,
    input wire logic suction_valve,
    input wire logic blow_valve,
    input wire logic first_status_lamp,
    input wire logic second_status_lamp,
    input wire logic valve_protect_en,
    input wire logic [2:0] disp_dp,
    input wire ejc_pkg::ejc_err_t disp_err,
    input wire ejc_pkg::ejc_unit_t disp_unit
);
    import ejc_pkg::*;
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_manual_input_edge;
        !valve_protect_en && $changed(suction_in_pin);
    endsequence
    a_lamps_same_phase: assert property (!valve_protect_en && $past(!valve_protect_en) |->
        first_status_lamp == second_status_lamp) else $error("lamps out of phase");
    a_blow_cancels_suction: assert property (blow_valve && valve_protect_en |->
        !suction_valve) else $error("suction kept during blow");
    a_manual_edit_refused: assert property (psel && penable && pwrite &&
        paddr == OFS_CFG && !valve_protect_en |-> pslverr) else $error("edit in manual");
    a_input_ends_manual: assert property (s_manual_input_edge |->
        ##[1:4] valve_protect_en) else $error("manual not left");
    a_blow_needs_volt: assert property ($rose(blow_valve) && !valve_protect_en |->
        $past(actuator_volt_ok, 4)) else $error("blow without supply");
    a_unit_legal: assert property (disp_unit != 2'b11) else $error("bad unit");
    a_page_onehot: assert property ($onehot0(disp_dp)) else $error("page marker");
    a_err_codes: assert property (disp_err inside {ERR_NONE, ERR_CAL_RANGE, ERR_UNDERVOLT})
        else $error("bad error code");
    a_zero_wait: assert property (psel && penable |-> pready) else $error("wait state");
endmodule : ejc_ctrl_asserts
bind ejc_ctrl ejc_ctrl_asserts chk_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pready, .pslverr, .suction_in_pin, .actuator_volt_ok, .suction_valve, .blow_valve,
    .first_status_lamp, .second_status_lamp, .valve_protect_en, .disp_dp, .disp_err, .disp_unit);

// file: tb/ejc_host_model.sv
`timescale 1ns/1ns
module ejc_host_model (
    input wire logic sinking,
    input wire logic suck,
    input wire logic blow,
    output logic suction_in_pin,
    output logic blow_in_pin
);
    // Sinking outputs idle high, active low
    assign suction_in_pin = suck ^ sinking;
    assign blow_in_pin = blow ^ sinking;
endmodule : ejc_host_model

// file: tb/ejc_ctrl_tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module ejc_ctrl_tb_top;
import ejc_pkg::*;
logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, suck = 0, blow = 0, snk = 0;
logic volt = 1, si, bi, e;
logic [7:0] paddr = 0;
logic [31:0] pwdata = 0, r;
ejc_keys_t keys = '0;
logic signed [11:0] raw = 0;
int n_mismatch = 0, n_compared = 0, cyc = 0;
always #25 pclk = ~pclk;
ejc_host_model host_u (.sinking(snk), .suck(suck), .blow(blow), .suction_in_pin(si),
    .blow_in_pin(bi));
ejc_ctrl #(.HOLD_CYCLES(20), .UNLOCK_WIN_CYCLES(50), .FLASH_HALF_CYCLES(4)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(), .pslverr(), .key_pins(keys),
    .suction_in_pin(si), .blow_in_pin(bi), .actuator_volt_ok(volt), .vacuum_raw(raw),
    .suction_valve(), .blow_valve(), .switch_out_pin(), .first_status_lamp(),
    .second_status_lamp(), .valve_protect_en(), .disp_value(), .disp_dp(), .disp_err(),
    .disp_unit(), .disp_rotated());
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (dut_u.pready !== 1'b1);
    r = dut_u.prdata;
    e = dut_u.pslverr;
    psel <= 0; penable <= 0;
endtask : apb
task automatic tick(input int n);
    repeat (n) @(posedge pclk);
endtask : tick
task automatic key(input logic [3:0] k, input int n);
    keys <= k;
    tick(n);
    keys <= '0;
    tick(6);
endtask : key
task automatic test_done;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
endtask : test_done
always @(posedge pclk) begin
    cyc++;
    if (cyc == 6000) begin
        n_mismatch++;
        test_done;
    end
end
initial begin
    tick(20);
    presetn <= 1;
    apb(0, OFS_STATUS, 0); `CHK(r[0], 1'b0)
    apb(0, OFS_CFG, 0); `CHK(r[2], 1'b0)
    suck <= 1; tick(5); `CHK(dut_u.suction_valve, 1'b1)
    blow <= 1; tick(5); `CHK({dut_u.suction_valve, dut_u.blow_valve}, 2'b01)
    blow <= 0; suck <= 0; tick(5);
    apb(0, OFS_CNT1, 0); `CHK(r, 32'h1)
    apb(1, OFS_CFG, 32'h4); snk <= 1; suck <= 1; tick(5);
    `CHK({dut_u.suction_valve, dut_u.switch_out_pin}, 2'b11)
    suck <= 0; tick(5); apb(1, OFS_CFG, 0); snk <= 0; tick(5);
    for (int u = 0; u < 3; u++) begin
        apb(1, OFS_CFG, u); tick(2); `CHK(dut_u.disp_unit, u[1:0])
    end
    apb(1, OFS_CFG, 32'h10); tick(2); `CHK(dut_u.disp_rotated, 1'b1)
    apb(1, OFS_CFG, 0);
    $display("auto and config done");
    volt <= 0; key(4'hc, 30); `CHK(dut_u.valve_protect_en, 1'b0)
    apb(1, OFS_CFG, 1); `CHK(e, 1'b1)
    r[0] = dut_u.first_status_lamp; tick(4); `CHK(dut_u.first_status_lamp, ~r[0])
    `CHK(dut_u.second_status_lamp, ~r[0])
    keys <= 4'h4; tick(6); `CHK({dut_u.blow_valve, dut_u.disp_err}, {1'b0, ERR_UNDERVOLT})
    keys <= '0; volt <= 1; tick(6);
    key(4'h8, 3); `CHK(dut_u.suction_valve, 1'b1)
    key(4'h8, 3); `CHK(dut_u.suction_valve, 1'b0)
    keys <= 4'h4; tick(6); `CHK(dut_u.blow_valve, 1'b1)
    keys <= '0; tick(6); `CHK(dut_u.blow_valve, 1'b0)
    key(4'h2, 3); `CHK(dut_u.valve_protect_en, 1'b1)
    key(4'hc, 30); `CHK(dut_u.valve_protect_en, 1'b0)
    suck <= 1; tick(6); `CHK(dut_u.valve_protect_en, 1'b1)
    suck <= 0; tick(6);
    $display("manual done");
    apb(1, OFS_PIN, 32'h1234); tick(60);
    apb(1, OFS_CFG, 1); `CHK(e, 1'b1)
    apb(1, OFS_UNLOCK, 32'h1234); apb(1, OFS_CFG, 1); `CHK(e, 1'b0)
    tick(60); apb(1, OFS_CFG, 0); `CHK(e, 1'b1)
    apb(1, OFS_UNLOCK, 32'h1234); apb(1, OFS_PIN, 0); tick(60);
    apb(1, OFS_CFG, 0); `CHK(e, 1'b0)
    raw <= 12'sd62; apb(1, OFS_ZERO, 0); tick(2); `CHK(dut_u.disp_err, ERR_CAL_RANGE)
    raw <= 12'sd61; apb(1, OFS_ZERO, 0); tick(2); `CHK(dut_u.disp_err, ERR_NONE)
    raw <= 12'sd900; apb(1, OFS_CFG, 32'h68); tick(3); `CHK(dut_u.switch_out_pin, 1'b0)
    `CHK({dut_u.disp_dp, dut_u.disp_value}, {3'b001, 10'h2})
    key(4'h8, 3); `CHK({dut_u.disp_dp, dut_u.disp_value}, {3'b010, 10'h0})
    key(4'h1, 25); `CHK(dut_u.switch_out_pin, 1'b1)
    apb(0, OFS_CNT1, 0); `CHK(r, 32'h2)
    raw <= 12'sd600; tick(3); `CHK(dut_u.second_status_lamp, 1'b1)
    raw <= 12'sd599; tick(3); `CHK(dut_u.second_status_lamp, 1'b0)
    $display("lock and zero done");
    test_done;
end
endmodule : ejc_ctrl_tb_top
